// File: core/fault_supervisor_pkg.sv
// Constants and types for the buck converter fault supervisor.
// Assumes a single 250 MHz system clock; all condition inputs are synchronous.
package fault_supervisor_pkg;

  localparam int CLK_MHZ          = 250;
  localparam int OVERLOAD_TIME_US = 50;   // Longest tolerated overload
  localparam int PG_DELAY_US      = 90;   // Power-good delay after 90 percent
  localparam int HICCUP_OFF_US    = 200;  // Hiccup shutdown wait
  localparam int OVERLOAD_CYCLES  = OVERLOAD_TIME_US * CLK_MHZ;
  localparam int PG_DELAY_CYCLES  = PG_DELAY_US * CLK_MHZ;
  localparam int HICCUP_CYCLES    = HICCUP_OFF_US * CLK_MHZ;
  localparam int TIMER_WIDTH      = 17;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SOFT_START,
    ST_RUN,
    ST_HICCUP,
    ST_LATCHED
  } sup_state_type;

endpackage : fault_supervisor_pkg

// File: core/delay_timer_if.sv
// Interface between the supervisor and its delay timer.
// Assumes one clock domain shared by both modules.
`timescale 1ns/1ns
interface delay_timer_if #(parameter int WIDTH = 17);
  logic             run;    // Count while high, clear when low
  logic [WIDTH-1:0] limit;  // Cycles to reach
  logic             done;   // Held high once limit reached
  modport owner (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface : delay_timer_if

// File: core/delay_timer.sv
// Restartable cycle counter used for overload, power-good and hiccup delays.
// Assumes the owner drops run to restart a measurement.
`timescale 1ns/1ns
module delay_timer
  import fault_supervisor_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
)(
  input  wire logic   clk_sys_in,
  input  wire logic   sys_rst_in,
  delay_timer_if.timer tmr
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             done;
  } timer_state_type;

  timer_state_type cur;
  timer_state_type next_cur;

  // Count up while run holds, saturate at the limit
  always_comb
  begin
    next_cur = cur;
    if (!tmr.run)
    begin
      next_cur.count = '0;
      next_cur.done  = 1'b0;
    end
    else if (cur.count >= tmr.limit)
      next_cur.done = 1'b1;
    else
      next_cur.count = cur.count + 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign tmr.done = cur.done;
endmodule : delay_timer

// File: core/buck_fault_supervisor.sv
// Fault supervisor: decides switching, soft-start, hiccup and latch-off.
// Assumes comparator inputs are synchronous to clk_sys_in and debounced.
`timescale 1ns/1ns
module buck_fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int OVERLOAD_LIMIT = OVERLOAD_CYCLES,
  parameter int PG_DELAY       = PG_DELAY_CYCLES,
  parameter int HICCUP_LIMIT   = HICCUP_CYCLES
)(
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic enable_in,          // Enable pin level
  input  wire logic vin_ok_in,          // Input above undervoltage_lockout
  input  wire logic bias_ok_in,         // Bias and bootstrap supplies good
  input  wire logic fb_above_90_in,     // Feedback above 90 percent
  input  wire logic fb_below_85_in,     // Feedback below 85 percent
  input  wire logic fb_above_115_in,    // Feedback above 115 percent
  input  wire logic load_sourcing_in,   // Load pushes current into output
  input  wire logic overload_in,        // Valley current limit active
  input  wire logic temp_warn_in,       // Junction above warning threshold
  input  wire logic temp_warn_clr_in,   // Junction below warning release
  input  wire logic temp_shut_in,       // Junction above thermal_shutdown
  input  wire logic temp_shut_clr_in,   // Junction below shutdown release
  input  wire logic switch_short_in,    // Series switch drop above 2 V
  input  wire logic on_time_long_in,    // On-time beyond 4 us
  input  wire logic ss_done_in,         // Soft-start ramp completed
  output logic      switching_en_out,   // Power stage allowed to switch
  output logic      ss_discharge_out,   // Hold soft-start capacitor empty
  output logic      neg_limit_en_out,   // Regulate to negative_valley_limit
  output logic      power_good_flag_out,
  output logic      fault_warn_n_out    // Fault warning, low when asserted
);

  // Refuse delay counts that the shared timer cannot reach
  if (OVERLOAD_LIMIT < 1 || OVERLOAD_LIMIT >= (1 << TIMER_WIDTH) ||
      PG_DELAY < 1 || PG_DELAY >= (1 << TIMER_WIDTH) ||
      HICCUP_LIMIT < 1 || HICCUP_LIMIT >= (1 << TIMER_WIDTH))
  begin : g_bad_counts
    $error("delay counts must fit the timer width");
  end

  // What the shared timer is measuring; a change of use restarts it
  typedef enum logic [1:0] {
    TMR_IDLE,
    TMR_OVERLOAD,
    TMR_PG_DELAY,
    TMR_HICCUP
  } timer_use_type;

  // Whole supervisor state, registered as one word
  typedef struct packed {
    sup_state_type state;
    timer_use_type tmr_use;    // Timer use of the last cycle
    logic          warm;       // Thermal warning latched
    logic          hot;        // Thermal shutdown latched
    logic          en_prev;
    logic          vin_prev;
    logic          sw_en;
    logic          ss_dis;
    logic          neg_lim;
    logic          pg;
    logic          warn_n;
  } sup_type;

  sup_type cur;
  sup_type next_cur;

  // One timer serves overload, power-good delay and hiccup off time
  delay_timer_if #(.WIDTH(TIMER_WIDTH)) tmr_if ();

  delay_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .tmr        (tmr_if)
  );

  logic restart_edge;
  logic start_ok;
  logic fb_window;
  timer_use_type tmr_use;
  logic tmr_done;

  // Enable or input rising edge re-arms a latched fault
  assign restart_edge = (enable_in && !cur.en_prev) || (vin_ok_in && !cur.vin_prev);
  // Conditions needed before a soft-start may begin
  assign start_ok = enable_in && vin_ok_in && bias_ok_in && !fb_above_115_in
                    && !cur.hot;
  assign fb_window = fb_above_90_in && !fb_above_115_in;

  // Timer sharing: overload in run, power-good delay in run, off time in hiccup
  always_comb
  begin
    tmr_use      = TMR_IDLE;
    tmr_if.run   = 1'b0;
    tmr_if.limit = TIMER_WIDTH'(PG_DELAY);
    case (cur.state)
      ST_RUN:
      begin
        if (overload_in)
        begin
          tmr_use      = TMR_OVERLOAD;
          tmr_if.run   = 1'b1;
          tmr_if.limit = TIMER_WIDTH'(OVERLOAD_LIMIT);
        end
        else
        begin
          tmr_use      = TMR_PG_DELAY;
          tmr_if.run   = fb_window && !cur.pg;
          tmr_if.limit = TIMER_WIDTH'(PG_DELAY);
        end
      end
      ST_HICCUP:
      begin
        tmr_use      = TMR_HICCUP;
        tmr_if.run   = 1'b1;
        tmr_if.limit = TIMER_WIDTH'(HICCUP_LIMIT);
      end
      default:
      begin
        tmr_use      = TMR_IDLE;
        tmr_if.run   = 1'b0;
        tmr_if.limit = TIMER_WIDTH'(PG_DELAY);
      end
    endcase
    // A new use starts from zero: one idle cycle clears the old count
    if (tmr_use != cur.tmr_use)
      tmr_if.run = 1'b0;
  end

  // Done counts only for the use that started the measurement
  assign tmr_done = tmr_if.done && (tmr_use == cur.tmr_use);

  // Next-state and flag decisions
  always_comb
  begin
    next_cur          = cur;
    next_cur.en_prev  = enable_in;
    next_cur.vin_prev = vin_ok_in;
    next_cur.tmr_use  = tmr_use;

    // Thermal hysteresis latches
    if (temp_warn_in)
      next_cur.warm = 1'b1;
    else if (temp_warn_clr_in)
      next_cur.warm = 1'b0;
    if (temp_shut_in)
      next_cur.hot = 1'b1;
    else if (temp_shut_clr_in)
      next_cur.hot = 1'b0;

    case (cur.state)
      ST_OFF:
        if (start_ok)
          next_cur.state = ST_SOFT_START;
      ST_SOFT_START:
        if (ss_done_in)
          next_cur.state = ST_RUN;
      ST_RUN:
        if (overload_in && tmr_done)
          next_cur.state = ST_HICCUP;
      ST_HICCUP:
        if (tmr_done)
          next_cur.state = ST_OFF;
      ST_LATCHED:
        if (restart_edge)
          next_cur.state = ST_OFF;
      default:
        next_cur.state = ST_OFF;
    endcase

    // Stopping conditions override, latched faults first; the others not in hiccup or latch-off
    if (switch_short_in || on_time_long_in)
      next_cur.state = ST_LATCHED;
    else if (cur.state != ST_LATCHED && cur.state != ST_HICCUP)
    begin
      if (!enable_in || !vin_ok_in || !bias_ok_in || temp_shut_in || cur.hot)
        next_cur.state = ST_OFF;
      else if (fb_above_115_in && !load_sourcing_in && cur.state == ST_RUN)
        next_cur.state = ST_OFF;
    end

    // Outputs follow the chosen state
    next_cur.sw_en   = (next_cur.state == ST_SOFT_START) || (next_cur.state == ST_RUN);
    next_cur.ss_dis  = !next_cur.sw_en;
    next_cur.neg_lim = (next_cur.state == ST_RUN) && fb_above_115_in
                       && load_sourcing_in;
    if (next_cur.state == ST_RUN && cur.state == ST_RUN)
    begin
      if (fb_below_85_in || !fb_window)
        next_cur.pg = 1'b0;
      else if (!cur.pg && !overload_in && tmr_done)
        next_cur.pg = 1'b1;
    end
    else
      next_cur.pg = 1'b0;

    if (next_cur.state == ST_LATCHED || next_cur.hot)
      next_cur.warn_n = 1'b0;
    else
      next_cur.warn_n = !next_cur.warm;
  end

  // State register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cur        <= '0;
      cur.state  <= ST_OFF;
      cur.ss_dis <= 1'b1;
      cur.warn_n <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign switching_en_out    = cur.sw_en;
  assign ss_discharge_out    = cur.ss_dis;
  assign neg_limit_en_out    = cur.neg_lim;
  assign power_good_flag_out = cur.pg;
  assign fault_warn_n_out    = cur.warn_n;
endmodule : buck_fault_supervisor

// File: sim/fault_supervisor_properties.sv
// Checker for the fault supervisor outputs against its condition inputs.
// Bound into buck_fault_supervisor; sees its ports only.
`timescale 1ns/1ns
module fault_supervisor_properties #(
  parameter int OVERLOAD_LIMIT = 20,
  parameter int PG_DELAY       = 30
)(
  input wire logic clk_sys_in, sys_rst_in, enable_in, vin_ok_in,
  input wire logic fb_above_90_in, fb_above_115_in, load_sourcing_in,
  input wire logic overload_in, temp_shut_in, switch_short_in, ss_done_in,
  input wire logic switching_en_out, ss_discharge_out, neg_limit_en_out,
  input wire logic power_good_flag_out, fault_warn_n_out
);
  int win;
  int ovl;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Run lengths of the feedback window and of an overload in regulation
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      win <= 0;
      ovl <= 0;
    end
    else
    begin
      win <= (fb_above_90_in && switching_en_out) ? win + 1 : 0;
      ovl <= (overload_in && switching_en_out && ss_done_in) ? ovl + 1 : 0;
    end
  property p_short;
    switch_short_in |=> !switching_en_out && !power_good_flag_out && !fault_warn_n_out;
  endproperty
  a_short: assert property (p_short) else $error("short did not latch off");
  property p_vin;
    !vin_ok_in |=> !switching_en_out && !power_good_flag_out;
  endproperty
  a_vin: assert property (p_vin) else $error("low input kept switching");
  property p_hot;
    temp_shut_in |=> !switching_en_out && !power_good_flag_out && !fault_warn_n_out;
  endproperty
  a_hot: assert property (p_hot) else $error("hot die kept switching");
  property p_ov;
    fb_above_115_in && !load_sourcing_in && power_good_flag_out |=> !switching_en_out;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage kept switching");
  property p_src;
    $rose(neg_limit_en_out) |-> $past(fb_above_115_in) && $past(load_sourcing_in);
  endproperty
  a_src: assert property (p_src) else $error("negative limit without cause");
  property p_start;
    $rose(switching_en_out) |-> $past(enable_in) && $past(vin_ok_in) && !$past(temp_shut_in);
  endproperty
  a_start: assert property (p_start) else $error("start without conditions");
  property p_dis;
    ss_discharge_out != switching_en_out;
  endproperty
  a_dis: assert property (p_dis) else $error("discharge not opposite switching");
  property p_pg;
    $rose(power_good_flag_out) |-> win >= PG_DELAY;
  endproperty
  a_pg: assert property (p_pg) else $error("power good raised early");
  property p_ovl;
    ovl <= OVERLOAD_LIMIT + 5;
  endproperty
  a_ovl: assert property (p_ovl) else $error("long overload not stopped");
endmodule : fault_supervisor_properties

bind buck_fault_supervisor fault_supervisor_properties #(
  .OVERLOAD_LIMIT(OVERLOAD_LIMIT), .PG_DELAY(PG_DELAY)) i_fault_supervisor_properties (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in),
  .vin_ok_in(vin_ok_in), .fb_above_90_in(fb_above_90_in), .fb_above_115_in(fb_above_115_in),
  .load_sourcing_in(load_sourcing_in), .overload_in(overload_in),
  .temp_shut_in(temp_shut_in), .switch_short_in(switch_short_in), .ss_done_in(ss_done_in),
  .switching_en_out(switching_en_out), .ss_discharge_out(ss_discharge_out),
  .neg_limit_en_out(neg_limit_en_out), .power_good_flag_out(power_good_flag_out),
  .fault_warn_n_out(fault_warn_n_out));

// File: sim/stage_model.sv
// Behavioural power stage: soft-start ramp and feedback comparators.
// Assumes the supervisor's switching enable on the same clock.
`timescale 1ns/1ns
module stage_model #(parameter int RAMP = 10)(
  input  wire logic clk_sys_in,
  input  wire logic switching_en_in,
  input  wire logic overload_in,
  output logic      ss_done_out,
  output logic      fb_above_90_out,
  output logic      fb_below_85_out
);
  int ramp;
  // Ramp climbs only while switching, empties when stopped
  always_ff @(posedge clk_sys_in)
    ramp <= switching_en_in ? ((ramp < RAMP) ? ramp + 1 : ramp) : 0;
  // Output folds back under overload
  assign ss_done_out     = (ramp == RAMP);
  assign fb_above_90_out = ss_done_out && !overload_in;
  assign fb_below_85_out = !fb_above_90_out;
endmodule : stage_model

// File: sim/tb_buck_fault_supervisor.sv
// Self-checking bench for the buck fault supervisor with a stage model.
// Uses shortened delay counts; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_buck_fault_supervisor;
  localparam int OVL = 20;
  localparam int HIC = 40;
  localparam int PGD = 30;
  logic clk_sys_in, sys_rst_in, enable_in, vin_ok_in, bias_ok_in, fb_above_115_in;
  logic temp_warn_clr_in, temp_shut_clr_in;
  logic load_sourcing_in, overload_in, temp_warn_in, temp_shut_in, switch_short_in;
  logic on_time_long_in, ss_done_in, fb_above_90_in, fb_below_85_in, switching_en_out;
  logic ss_discharge_out, neg_limit_en_out, power_good_flag_out, fault_warn_n_out;
  int   n_mismatch, tests_run, waited, len;
  buck_fault_supervisor #(.OVERLOAD_LIMIT(OVL), .PG_DELAY(PGD), .HICCUP_LIMIT(HIC))
    i_buck_fault_supervisor (.clk_sys_in, .sys_rst_in, .enable_in, .vin_ok_in, .bias_ok_in,
    .fb_above_90_in, .fb_below_85_in, .fb_above_115_in, .load_sourcing_in, .overload_in,
    .temp_warn_in, .temp_warn_clr_in, .temp_shut_in,
    .temp_shut_clr_in, .switch_short_in, .on_time_long_in, .ss_done_in,
    .switching_en_out, .ss_discharge_out, .neg_limit_en_out, .power_good_flag_out,
    .fault_warn_n_out);
  stage_model i_stage_model (.clk_sys_in, .switching_en_in(switching_en_out), .overload_in,
    .ss_done_out(ss_done_in), .fb_above_90_out(fb_above_90_in),
    .fb_below_85_out(fb_below_85_in));
  // Clock and watchdog
  initial
  begin
    clk_sys_in = 0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : tick
  task automatic chk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic clear();
    {fb_above_115_in, load_sourcing_in, overload_in, temp_warn_in} = 4'h0;
    {temp_shut_in, switch_short_in, on_time_long_in, vin_ok_in, bias_ok_in} = 5'h3;
    {temp_warn_clr_in, temp_shut_clr_in} = 2'h3;
  endtask : clear
  // Restart from enable low then high; ramp holds power good low
  task automatic kick();
    enable_in = 0;
    tick(2);
    enable_in = 1;
    tick(2);
    chk("start switching", 1'b1, switching_en_out);
    chk("ramp power good", 1'b0, power_good_flag_out);
  endtask : kick
  task automatic go_up();
    clear();
    enable_in = 1;
    waited = 0;
    do
    begin
      tick(1);
      waited++;
    end
    while (power_good_flag_out !== 1'b1 && waited < 400);
    chk("power good", 1'b1, power_good_flag_out);
    chk("fault warn", 1'b1, fault_warn_n_out);
  endtask : go_up
  // Expected {switching, power good, warn_n} for each injected condition
  function automatic logic [2:0] expect_out(input int k);
    case (k)
      0, 1, 5: return 3'h1;
      6:       return 3'h5;
      7:       return 3'h6;
      default: return 3'h0;
    endcase
  endfunction : expect_out
  task automatic run_case(input int k);
    logic [2:0] e;
    e = expect_out(k);
    go_up();
    case (k)
      0: vin_ok_in = 0;
      1: bias_ok_in = 0;
      2: {temp_shut_in, temp_shut_clr_in} = 2'h2;
      3: switch_short_in = 1;
      4: on_time_long_in = 1;
      5: fb_above_115_in = 1;
      6: {fb_above_115_in, load_sourcing_in} = 2'h3;
      default: {temp_warn_in, temp_warn_clr_in} = 2'h2;
    endcase
    tick(3);
    chk("switching", e[2], switching_en_out);
    chk("power good", e[1], power_good_flag_out);
    chk("fault warn", e[0], fault_warn_n_out);
    chk("discharge", ~e[2], ss_discharge_out);
    if (k == 6) chk("negative limit", 1'b1, neg_limit_en_out);
    // Between the two thermal thresholds the warning must hold
    if (k == 7)
    begin
      temp_warn_in = 0;
      tick(3);
      chk("warning held", 1'b0, fault_warn_n_out);
    end
    clear();
    tick(3);
    if (k == 7) chk("warning release", 1'b1, fault_warn_n_out);
    if (k == 3 || k == 4)
    begin
      chk("latched", 1'b0, switching_en_out);
      kick();
    end
    go_up();
    $display("case %0d done", k);
  endtask : run_case
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Main sequence: start-up, overloads, then every condition in turn
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    sys_rst_in = 1;
    enable_in = 0;
    clear();
    void'($urandom(61));
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    sys_rst_in = 0;
    kick();
    go_up();
    repeat (3)
    begin
      len = 3 + $urandom % (OVL - 6);
      overload_in = 1;
      tick(len);
      chk("short overload switching", 1'b1, switching_en_out);
      chk("short overload pg", 1'b0, power_good_flag_out);
      go_up();
      chk("no hiccup", 1'b1, waited < HIC);
    end
    overload_in = 1;
    tick(OVL + 6);
    chk("hiccup stop", 1'b0, switching_en_out);
    chk("hiccup warn", 1'b1, fault_warn_n_out);
    go_up();
    chk("hiccup wait", 1'b1, waited > HIC + PGD);
    for (int k = 0; k < 8; k++) run_case(k);
    repeat (4) run_case($urandom % 8);
    wrap_up();
  end
endmodule : tb_buck_fault_supervisor
